// ===== core/port_regs.vh
// Register offsets, field widths and reset values for the four-bit shared port
`ifndef PORT_REGS_VH
`define PORT_REGS_VH
`define PIN_COUNT 4
`define OFF_DATA 8'h00
`define OFF_DIR 8'h10
`define OFF_PULLUP 8'h34
`define OFF_KEYPAD 8'h38
`define DIR_RESET 4'h0
`define PULLUP_RESET 4'h0
`define KEYPAD_RESET 4'h0
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`endif

// ===== core/pin_cell.v
// One port pin: driver enable, pull-up control and the input level seen by the bus
`timescale 1ns/1ps
`default_nettype none
module pin_cell
(
	input wire latch_bit, // Stored latch value
	input wire dir_bit, // 1 selects output
	input wire pullup_bit, // Pull-up enable
	input wire pin_in, // Level on the pin
	output wire pin_out, // Value driven on the pin
	output wire pin_oe_n, // Low while the pin is driven
	output wire pullup_on, // Internal pull-up connected
	output wire read_bit // Value seen by a data read
);
	// Driver follows the direction bit only; latch writes never touch the input path
	assign pin_out = latch_bit;
	assign pin_oe_n = ~dir_bit;
	// Pull-up cut as soon as the pin becomes an output
	assign pullup_on = pullup_bit & ~dir_bit;
	// Output pins read back the latch, inputs read the pin
	assign read_bit = dir_bit ? latch_bit : pin_in;
endmodule
`default_nettype wire

// ===== core/in_sync.v
// Two-stage synchroniser bank for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module in_sync
(
	input wire hclk, // Bus clock
	input wire hresetn, // Asynchronous reset, active low
	input wire [3:0] d, // Raw pin levels
	output wire [3:0] q // Synchronised levels
);
	reg [3:0] stage1_reg;
	reg [3:0] stage2_reg;
	// Stage one feeds only stage two to keep metastability contained
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stage1_reg <= 4'h0;
			stage2_reg <= 4'h0;
		end
		else
		begin
			stage1_reg <= d;
			stage2_reg <= stage1_reg;
		end
	end
	assign q = stage2_reg;
endmodule
`default_nettype wire

// ===== core/shared_port.v
// Four-bit bidirectional port shared with the keypad interrupt inputs, AHB-Lite slave
// Contract
// - Four pins, each usable as general I/O or keypad interrupt input.
// - One data latch bit per pin, untouched by reset.
// - Keypad enable bit n makes pin n an interrupt input.
// - Direction 1 turns the driver on; 0 makes the pin an input.
// - Reset clears all direction bits, so every pin starts as input.
// - Data read returns the latch for pins set as outputs.
// - Data read returns the pin level for pins set as inputs.
// - Data writes always update the latch, whatever the direction.
// - Latch writes on input pins do not change the input level.
// - Pull-up acts only on input pins with pull-up enabled.
// - Input without pull-up floats; output drives regardless of pull-up.
// - Pull-up drops immediately when the direction selects output.
// - Pull-up enable 1 connects the pull-up, 0 disconnects it.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "port_regs.vh"
module shared_port
(
	input wire hclk, // Bus clock, 25 MHz
	input wire hresetn, // Asynchronous reset, active low
	input wire hsel, // Slave select
	input wire [31:0] haddr, // Byte address
	input wire [1:0] htrans, // Transfer type
	input wire hwrite, // 1 for write
	input wire [2:0] hsize, // Transfer size
	input wire [31:0] hwdata, // Write data
	input wire hready, // Bus ready in
	output reg [31:0] hrdata, // Read data
	output wire hreadyout, // Slave ready
	output wire hresp, // Always OKAY
	input wire [3:0] pin_in, // Pin levels
	output wire [3:0] pin_out, // Pin drive values
	output wire [3:0] pin_oe_n, // Low while the pin is driven
	output wire [3:0] pullup_on, // Internal pull-up connected
	output wire [3:0] keypad_inputs, // Levels to the keypad interrupt module
	output wire [3:0] keypad_irq_enable_bits // Pins claimed as interrupt inputs
);
	reg [3:0] pin_data_bits; // Latch, deliberately without reset
	reg [3:0] pin_direction_bits;
	reg [3:0] pin_pullup_enable;
	reg [3:0] keypad_irq_control;
	reg wr_pend_reg;
	reg [7:0] wr_addr_reg;
	wire [3:0] pin_sync;
	wire [3:0] read_bits;
	wire access;
	wire [7:0] off;

	assign access = hsel & hready & (htrans == `HTRANS_NONSEQ | htrans == `HTRANS_SEQ);
	assign off = haddr[7:0];
	assign hreadyout = 1'b1; // Zero wait states
	assign hresp = 1'b0;

	in_sync u_sync
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.d(pin_in),
		.q(pin_sync)
	);

	// One cell per pin
	genvar i;
	generate
		for (i = 0; i < `PIN_COUNT; i = i + 1)
		begin : g_pin
			pin_cell u_cell
			(
				.latch_bit(pin_data_bits[i]),
				.dir_bit(pin_direction_bits[i]),
				.pullup_bit(pin_pullup_enable[i]),
				.pin_in(pin_sync[i]),
				.pin_out(pin_out[i]),
				.pin_oe_n(pin_oe_n[i]),
				.pullup_on(pullup_on[i]),
				.read_bit(read_bits[i])
			);
		end
	endgenerate

	// Keypad module sees every pin level; it decides use from its enable bits
	assign keypad_inputs = pin_sync;
	assign keypad_irq_enable_bits = keypad_irq_control;

	// Latch write address during the address phase
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end
		else
		begin
			wr_pend_reg <= access & hwrite;
			wr_addr_reg <= off;
		end
	end

	// Data latch has no reset so its contents survive a system reset
	always @(posedge hclk)
	begin
		if (wr_pend_reg && wr_addr_reg == `OFF_DATA)
			pin_data_bits <= hwdata[3:0];
	end

	// Configuration registers; upper bits simply not stored
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_direction_bits <= `DIR_RESET;
			pin_pullup_enable <= `PULLUP_RESET;
			keypad_irq_control <= `KEYPAD_RESET;
		end
		else if (wr_pend_reg)
		begin
			if (wr_addr_reg == `OFF_DIR)
				pin_direction_bits <= hwdata[3:0];
			if (wr_addr_reg == `OFF_PULLUP)
				pin_pullup_enable <= hwdata[3:0];
			if (wr_addr_reg == `OFF_KEYPAD)
				keypad_irq_control <= hwdata[3:0];
		end
	end

	// Read data registered at the address phase; unmapped offsets read zero
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (access && !hwrite)
		begin
			case (off)
				`OFF_DATA: hrdata <= {28'h0000000, read_bits};
				`OFF_DIR: hrdata <= {28'h0000000, pin_direction_bits};
				`OFF_PULLUP: hrdata <= {28'h0000000, pin_pullup_enable};
				`OFF_KEYPAD: hrdata <= {28'h0000000, keypad_irq_control};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== testbench/shared_port_monitor.sv
// Assertion checker on the shared port's ports
`timescale 1ns/1ps
`default_nettype none
module shared_port_monitor
(
	input wire hclk, // Clock
	input wire hresetn, // Reset, low
	input wire hsel, // Select
	input wire [31:0] haddr, // Address
	input wire [1:0] htrans, // Transfer
	input wire hwrite, // Write
	input wire [31:0] hwdata, // Write data
	input wire [31:0] hrdata, // Read data
	input wire [3:0] pin_out, // Pin drive
	input wire [3:0] pin_oe_n, // Drive on, low
	input wire [3:0] pullup_on, // Pull-up on
	input wire [3:0] keypad_irq_enable_bits // Keypad enables
);
	// Accepted phases; this slave never stalls, so hready is not needed
	wire w = hsel & htrans[1] & hwrite;
	wire r = hsel & htrans[1] & ~hwrite;
	wire [7:0] a = haddr[7:0];
	wire [3:0] d = hwdata[3:0];
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_dir; w && a == 8'h10 |=> ##1 pin_oe_n == ~$past(d); endproperty
	a_dir: assert property (p_dir) else $error("bad drive enable");
	property p_dat; w && a == 8'h00 |=> ##1 pin_out == $past(d); endproperty
	a_dat: assert property (p_dat) else $error("bad latch");
	property p_kp; w && a == 8'h38 |=> ##1 keypad_irq_enable_bits == $past(d); endproperty
	a_kp: assert property (p_kp) else $error("bad keypad enable");
	property p_pu; w && a == 8'h34 |=> ##1 pullup_on == ($past(d) & pin_oe_n); endproperty
	a_pu: assert property (p_pu) else $error("bad pull-up");
	property p_off; (pullup_on & ~pin_oe_n) == 4'h0; endproperty
	a_off: assert property (p_off) else $error("pull-up on driven pin");
	property p_rst; disable iff (1'b0) !hresetn |-> pin_oe_n == 4'hF && pullup_on == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_rd; r && a == 8'h00 |=> ((hrdata[3:0] ^ $past(pin_out)) & ~$past(pin_oe_n)) == 4'h0;
	endproperty
	a_rd: assert property (p_rd) else $error("bad output pin read");
	property p_hi; r && (a == 8'h00 || a == 8'h10) |=> hrdata[31:4] == 28'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper bits set");
endmodule
bind shared_port shared_port_monitor i_mon (.*);
`default_nettype wire

// ===== testbench/pin_model.sv
// Pin side: outside driver, pull-ups and floating pins
`timescale 1ns/1ps
`default_nettype none
module pin_model
(
	input wire [3:0] pin_out, // Drive value
	input wire [3:0] pin_oe_n, // Drive on, low
	input wire [3:0] pullup_on, // Pull-up on
	input wire ext_en, // Outside driver on
	input wire [3:0] ext, // Outside value
	output wire [3:0] pin_in // Pin level
);
	// A floating pin wanders so a stale level never passes for a real one
	logic [3:0] flt = 4'h5;
	always #40 flt = ~flt;
	// Own driver wins, then the outside driver, then the pull-up
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (ext_en ? ext : pullup_on | flt));
endmodule
`default_nettype wire

// ===== testbench/four_bit_keyboard_shared_port_test.sv
// Self-checking bench for the shared port
`timescale 1ns/1ps
`default_nettype none
module four_bit_keyboard_shared_port_test;
	logic hclk = 1'b0;
	logic hresetn = 1'b1;
	logic hsel, hwrite, ext_en;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [3:0] pin_in, pin_out, pin_oe_n, pullup_on, keypad_irq_enable_bits, ext;
	logic [3:0] keypad_inputs;
	wire hreadyout;
	int n_fail = 0, checks_done = 0, cycles = 0;
	shared_port i_shared_port (.*, .hsize(3'h2), .hready(hreadyout), .hresp());
	pin_model i_pin_model (.*);
	// Clock and hang guard
	always #20 hclk = ~hclk;
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			complete_run;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One word transfer; idle cycles first let pin levels pass the synchroniser
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] e);
		repeat (3) @(posedge hclk);
		{hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, w ? e : 32'h0};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		if (!w) chk(hrdata, e);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		{hsel, hwrite, htrans, haddr, hwdata, ext_en, ext} = '0;
		#5 hresetn = 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(0, 8'h10, 32'h0);
		ext_en <= 1'b1;
		ext <= 4'hA;
		xfer(0, 8'h00, 32'hA);
		chk({28'h0, keypad_inputs}, 32'hA);
		xfer(1, 8'h00, 32'h5);
		xfer(0, 8'h00, 32'hA);
		xfer(1, 8'h10, 32'h3);
		xfer(0, 8'h00, 32'h9);
		ext_en <= 1'b0;
		xfer(1, 8'h34, 32'hF);
		xfer(0, 8'h00, 32'hD);
		chk({28'h0, pullup_on}, 32'hC);
		xfer(1, 8'h10, 32'hFFFFFFF0);
		xfer(0, 8'h10, 32'h0);
		xfer(0, 8'h20, 32'h0);
		xfer(1, 8'h38, 32'h5);
		@(negedge hclk) chk({28'h0, keypad_irq_enable_bits}, 32'h5);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk) chk({28'h0, keypad_irq_enable_bits}, 32'h0);
		xfer(0, 8'h10, 32'h0);
		xfer(1, 8'h10, 32'hF);
		xfer(0, 8'h00, 32'h5);
		complete_run;
	end
endmodule
`default_nettype wire
